// ---- verilog/lgsc_cfg.svh ----
// Constants for the low-side gate edge-rate control block
`ifndef LGSC_CFG_SVH
`define LGSC_CFG_SVH
// Register map
`define LGSC_ADDR_EDGE_CFG 12'h18F
`define LGSC_ADDR_MSB 11
`define LGSC_RW_BIT 15
`define LGSC_BANK_BIT 15
// Drivers and codes
`define LGSC_NDRV 7
`define LGSC_CODES_W 14
`define LGSC_CODE_300 2'h0
`define LGSC_CODE_50 2'h1
`define LGSC_CODE_25 2'h2
`define LGSC_CODE_12P5 2'h3
`define LGSC_CODES_RESET 14'h0000
// Serial frame
`define LGSC_CMD_LAST 6'h0F
`define LGSC_DATA_FIRST 6'h10
`define LGSC_FRAME_LAST 6'h1F
// Timing
`define LGSC_CLK_MHZ 250
`define LGSC_SLEW_SWITCH_NS 166
`define LGSC_SLEW_SWITCH_CYC ((`LGSC_SLEW_SWITCH_NS * `LGSC_CLK_MHZ) / 1000)
`endif

// ---- verilog/lgsc_pkg.sv ----
// Types for the low-side gate edge-rate control block
package lgsc_pkg;
  typedef enum logic {
    LGSC_MODE_NORMAL,
    LGSC_MODE_RUN
  } lgsc_mode_t;
  typedef logic [13:0] lgsc_codes_t;
  typedef logic [1:0] lgsc_code_t;
endpackage

// ---- verilog/lgsc_top.sv ----
// Low-side gate edge-rate control with serial config and safe gate state
//
// What this block does
// - Each of seven low-side drivers has its own 2-bit strength code.
// - Rising and falling edge codes per driver are chosen independently.
// - Writing a rising code also sets that driver's falling code to match.
// - Codes 00, 01, 10, 11 mean 300, 50, 25, 12.5 V/us.
// - Host writes codes at register 0x18F over serial, Normal mode only.
// - Reset leaves the block in Normal mode, writable at once.
// - Microcode request forces one driver's codes to the fastest rate.
// - A new setting reaches the code outputs within one clock.
// - Reset forces every gate output low immediately.
// - Gate high only with enable, no undervolt, clock ok and command.
`timescale 1ns/1ns
`include "lgsc_cfg.svh"

module lgsc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial register port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Mode control
  input wire logic mode_run_req,
  input wire logic mode_normal_req,
  output logic mode_is_normal,
  // Microcode fast-edge request
  input wire logic ucode_fast_req,
  input wire logic [2:0] ucode_fast_drv,
  // Gate qualifiers
  input wire logic drive_enable,
  input wire logic gate_supply_undervolt,
  input wire logic logic_supply_undervolt,
  input wire logic clock_monitor_enable,
  input wire logic [6:0] channel_cmd,
  // Gate and strength outputs
  output logic [6:0] gate_out,
  output logic [13:0] rise_code,
  output logic [13:0] fall_code
);

  // Force one driver's 2-bit field to the fastest code
  function automatic lgsc_pkg::lgsc_codes_t set_fast(
    input lgsc_pkg::lgsc_codes_t codes,
    input logic [2:0] drv
  );
    lgsc_pkg::lgsc_codes_t res;
    res = codes;
    for (int i = 0; i < `LGSC_NDRV; i++) begin
      if (drv == 3'(i)) begin
        res[2*i +: 2] = `LGSC_CODE_300;
      end
    end
    return res;
  endfunction

  lgsc_pkg::lgsc_mode_t mode_q;
  logic normal_q;
  lgsc_pkg::lgsc_codes_t rise_q;
  lgsc_pkg::lgsc_codes_t rise_d;
  lgsc_pkg::lgsc_codes_t fall_q;
  lgsc_pkg::lgsc_codes_t fall_d;
  logic bank_q;
  logic bank_d;
  logic [6:0] gate_q;
  logic gate_ok;

  logic sclk_q;
  logic sclk_prev_q;
  logic cs_n_q;
  logic mosi_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [5:0] bit_cnt_q;
  logic [15:0] shift_in_q;
  logic [15:0] word_in;
  logic [15:0] cmd_q;
  logic [15:0] shift_out_q;
  logic miso_q;
  logic miso_oe_q;
  logic [15:0] read_word;
  logic addr_hit;
  logic cmd_addr_hit;
  logic cmd_is_read;
  logic wr_commit;

  // Serial pins are synchronous; one stage gives a clean edge detect
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
      sclk_prev_q <= sclk_q;
      cs_n_q <= spi_cs_n;
      mosi_q <= spi_mosi;
    end
  end

  assign sclk_rise = sclk_q & ~sclk_prev_q & ~cs_n_q;
  assign sclk_fall = ~sclk_q & sclk_prev_q & ~cs_n_q;
  assign word_in = {shift_in_q[14:0], mosi_q};
  assign addr_hit = (word_in[`LGSC_ADDR_MSB:0] == `LGSC_ADDR_EDGE_CFG);
  assign cmd_addr_hit = (cmd_q[`LGSC_ADDR_MSB:0] == `LGSC_ADDR_EDGE_CFG);
  assign cmd_is_read = word_in[`LGSC_RW_BIT];

  // Writes outside Normal mode are dropped silently
  assign wr_commit = sclk_rise &&
                     (bit_cnt_q == `LGSC_FRAME_LAST) &&
                     !cmd_q[`LGSC_RW_BIT] &&
                     cmd_addr_hit &&
                     (mode_q == lgsc_pkg::LGSC_MODE_NORMAL);

  // Bit counter and input shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 16'h0000;
      cmd_q <= 16'h0000;
    end else if (cs_n_q) begin
      bit_cnt_q <= 6'h00;
    end else if (sclk_rise) begin
      shift_in_q <= word_in;
      bit_cnt_q <= bit_cnt_q + 6'h01;
      if (bit_cnt_q == `LGSC_CMD_LAST) begin
        cmd_q <= word_in;
      end
    end
  end

  // Readback shows the bank named by the last write; bit 14 reads zero
  always_comb begin
    read_word = {bank_q, 1'b0, bank_q ? fall_q : rise_q};
  end

  // Output shifter; unmapped or write frames return zeros
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_q <= 16'h0000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= ~cs_n_q;
      if (cs_n_q) begin
        shift_out_q <= 16'h0000;
        miso_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == `LGSC_CMD_LAST) begin
        shift_out_q <= (cmd_is_read && addr_hit) ? read_word : 16'h0000;
      end else if (sclk_fall && bit_cnt_q >= `LGSC_DATA_FIRST) begin
        miso_q <= shift_out_q[15];
        shift_out_q <= {shift_out_q[14:0], 1'b0};
      end
    end
  end

  // Mode: Normal after reset, run request wins a tie
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= lgsc_pkg::LGSC_MODE_NORMAL;
      normal_q <= 1'b1;
    end else if (mode_run_req) begin
      mode_q <= lgsc_pkg::LGSC_MODE_RUN;
      normal_q <= 1'b0;
    end else if (mode_normal_req) begin
      mode_q <= lgsc_pkg::LGSC_MODE_NORMAL;
      normal_q <= 1'b1;
    end
  end

  // Next strength codes; microcode wins over a same-cycle serial write
  always_comb begin
    rise_d = rise_q;
    fall_d = fall_q;
    bank_d = bank_q;
    if (wr_commit) begin
      bank_d = word_in[`LGSC_BANK_BIT];
      if (!word_in[`LGSC_BANK_BIT]) begin
        rise_d = word_in[13:0];
        fall_d = word_in[13:0];
      end else begin
        fall_d = word_in[13:0];
      end
    end
    if (ucode_fast_req && ucode_fast_drv < 3'(`LGSC_NDRV)) begin
      rise_d = set_fast(rise_d, ucode_fast_drv);
      fall_d = set_fast(fall_d, ucode_fast_drv);
    end
  end

  // Codes drive the pre-driver straight from flops, one clock after a
  // change, far inside the allowed switching time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q <= `LGSC_CODES_RESET;
      fall_q <= `LGSC_CODES_RESET;
      bank_q <= 1'b0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      bank_q <= bank_d;
    end
  end

  assign gate_ok = drive_enable &&
                   !gate_supply_undervolt &&
                   !logic_supply_undervolt &&
                   clock_monitor_enable;

  // Async reset clears the gates without waiting for a clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 7'h00;
    end else begin
      gate_q <= {7{gate_ok}} & channel_cmd;
    end
  end

  // Code meaning is fixed by the analog stage: 00 fastest, 11 slowest
  // Status pin comes from its own flop, not a decode, so it cannot glitch

  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;
  assign mode_is_normal = normal_q;
  assign gate_out = gate_q;
  assign rise_code = rise_q;
  assign fall_code = fall_q;

endmodule // lgsc_top

// ---- bench/lgsc_top_checker.sv ----
// Assertion checker for the low-side gate edge-rate block
`timescale 1ns/1ns
module lgsc_top_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic mode_is_normal,
  input wire logic ucode_fast_req,
  input wire logic [2:0] ucode_fast_drv,
  input wire logic drive_enable,
  input wire logic gate_supply_undervolt,
  input wire logic logic_supply_undervolt,
  input wire logic clock_monitor_enable,
  input wire logic [6:0] channel_cmd,
  input wire logic [6:0] gate_out,
  input wire logic [13:0] rise_code,
  input wire logic [13:0] fall_code
);
  wire logic ok = drive_enable && !gate_supply_undervolt &&
    !logic_supply_undervolt && clock_monitor_enable;
  a_gate_when_ok: assert property (@(posedge sys_clk)
    disable iff (!rst_n) ok |=> gate_out == $past(channel_cmd))
    else $error("gate not following command");
  a_gate_off_bad: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !ok |=> gate_out == 7'h00)
    else $error("gate on while unsafe");
  // No disable here: the gate must be low during reset itself
  a_reset_gate_low: assert property (@(posedge sys_clk)
    !rst_n |-> gate_out == 7'h00) else $error("gate on in reset");
  a_mode_after_reset: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !$past(rst_n) |-> mode_is_normal)
    else $error("not normal after reset");
  a_fast_rise_code: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (ucode_fast_req && ucode_fast_drv != 3'h7)
    |=> rise_code[$past(ucode_fast_drv) * 2 +: 2] == 2'h0)
    else $error("rise code not fastest");
  a_fast_fall_code: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (ucode_fast_req && ucode_fast_drv != 3'h7)
    |=> fall_code[$past(ucode_fast_drv) * 2 +: 2] == 2'h0)
    else $error("fall code not fastest");
  a_codes_hold_idle: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (spi_cs_n && !ucode_fast_req)[*4]
    |=> $stable(rise_code) && $stable(fall_code))
    else $error("codes moved without a request");
  a_rise_pairs_fall: assert property (@(posedge sys_clk)
    disable iff (!rst_n) ($changed(rise_code) && !$past(ucode_fast_req))
    |-> fall_code == rise_code) else $error("fall not matching rise");
  a_oe_follows_select: assert property (@(posedge sys_clk)
    disable iff (!rst_n) spi_miso_oe == !$past(spi_cs_n, 2))
    else $error("miso enable not following select");
endmodule // lgsc_top_checker
bind lgsc_top lgsc_top_checker i_lgsc_top_checker (.sys_clk, .rst_n,
  .spi_cs_n, .spi_miso_oe, .mode_is_normal, .ucode_fast_req,
  .ucode_fast_drv,
  .drive_enable, .gate_supply_undervolt, .logic_supply_undervolt,
  .clock_monitor_enable, .channel_cmd, .gate_out, .rise_code, .fall_code);

// ---- bench/lgsc_host_model.sv ----
// Serial host model that writes and reads the edge-rate register
`timescale 1ns/1ns
module lgsc_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Slow serial clock: the block samples sclk with sys_clk
  task automatic xfer(input logic [31:0] frame, output logic [15:0] rd);
    @(negedge sys_clk) cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = frame[i];
      repeat (6) @(negedge sys_clk);
      if (i < 16) rd[i] = miso;
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule // lgsc_host_model

// ---- bench/lgsc_top_test.sv ----
// Self-checking bench for the low-side gate edge-rate block
`timescale 1ns/1ns
module lgsc_top_test;
  logic sys_clk = 1'b0, rst_n = 1'b1, cs_n, sclk, mosi, miso, normal;
  logic run_req = 1'b0, nrm_req = 1'b0, fast_req = 1'b0, den = 1'b1;
  logic gsu = 1'b0, lsu = 1'b0, cme = 1'b1;
  logic [2:0] fast_drv = 3'h0;
  logic [6:0] cmd = 7'h7F, gate;
  logic [13:0] rise, fall;
  logic [15:0] rd;
  int fails = 0, checks_done = 0;
  always #2 sys_clk = ~sys_clk;
  lgsc_top i_lgsc_top (.sys_clk, .rst_n, .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(), .mode_run_req(run_req),
    .mode_normal_req(nrm_req), .mode_is_normal(normal),
    .ucode_fast_req(fast_req), .ucode_fast_drv(fast_drv), .drive_enable(den),
    .gate_supply_undervolt(gsu), .logic_supply_undervolt(lsu),
    .clock_monitor_enable(cme), .channel_cmd(cmd), .gate_out(gate),
    .rise_code(rise), .fall_code(fall));
  lgsc_host_model i_lgsc_host_model (.sys_clk, .cs_n, .sclk, .mosi, .miso);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic xf(input logic [31:0] f);
    i_lgsc_host_model.xfer(f, rd);
  endtask
  task automatic t_reset();
    // A real falling edge on reset clears the flops before the first clock
    #1 rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk({9'h0, gate}, 16'h0);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({15'h0, normal}, 16'h1);
    chk({2'h0, rise}, 16'h0);
    $display("reset test done");
  endtask
  task automatic t_write();
    xf(32'h018F_3939);
    chk({2'h0, rise}, 16'h3939);
    chk({2'h0, fall}, 16'h3939);
    xf(32'h018F_86C6);
    chk({2'h0, fall}, 16'h06C6);
    chk({2'h0, rise}, 16'h3939);
    xf(32'h818F_0000);
    chk(rd, 16'h86C6);
    $display("write test done");
  endtask
  task automatic t_refuse();
    xf(32'h018E_1555);
    chk({2'h0, rise}, 16'h3939);
    @(negedge sys_clk) run_req = 1'b1;
    @(negedge sys_clk) run_req = 1'b0;
    chk({15'h0, normal}, 16'h0);
    xf(32'h018F_1555);
    chk({2'h0, rise}, 16'h3939);
    @(negedge sys_clk) nrm_req = 1'b1;
    @(negedge sys_clk) nrm_req = 1'b0;
    chk({15'h0, normal}, 16'h1);
    $display("refuse test done");
  endtask
  task automatic t_ucode();
    @(negedge sys_clk) fast_req = 1'b1;
    fast_drv = 3'h1;
    @(negedge sys_clk) fast_drv = 3'h7;
    chk({2'h0, rise}, 16'h3931);
    chk({2'h0, fall}, 16'h06C2);
    @(negedge sys_clk) fast_req = 1'b0;
    chk({2'h0, rise}, 16'h3931);
    $display("ucode test done");
  endtask
  task automatic t_gate();
    cmd = 7'h55;
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk) den = (i != 0);
      gsu = (i == 1);
      lsu = (i == 2);
      cme = (i != 3);
      @(negedge sys_clk);
      chk({9'h0, gate}, (i == 4) ? 16'h0055 : 16'h0);
    end
    // Reset mid-run drops the gate before any clock edge
    @(negedge sys_clk) rst_n = 1'b0;
    #1;
    chk({9'h0, gate}, 16'h0);
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({2'h0, rise}, 16'h0);
    chk({15'h0, normal}, 16'h1);
    $display("gate test done");
  endtask
  initial begin
    #50000;
    fails++;
    final_report();
  end
  initial begin
    t_reset();
    t_write();
    t_refuse();
    t_ucode();
    t_gate();
    final_report();
  end
endmodule // lgsc_top_test
